// ==== hw/literal_file_alu.sv ====
// Purpose: Executes xor/add immediate, and/add file, bit clear ops over Wishbone
// Assumes: One clock; port pins are asynchronous and pass two flops first
// Notes:   An opcode written to the instruction register runs in that cycle
`default_nettype none
module literal_file_alu
    import alu_ops_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADR_W-1:0]  adrI,
    input  wire logic [31:0]       datI,
    input  wire logic [3:0]        selI,
    input  wire logic              weI,
    input  wire logic              cycI,
    input  wire logic              stbI,
    output logic                   ackO,
    output logic      [31:0]       datO,
    input  wire logic [7:0]        portPins,
    output logic      [7:0]        portOut
);
    logic [7:0]  mem [0:127];
    logic [7:0]  acc_r,     acc_nxt;
    logic [2:0]  status_r,  status_nxt;
    logic [7:0]  timer_r,   timer_nxt;
    logic [7:0]  presc_r,   presc_nxt;
    logic [12:0] ip_r,      ip_nxt;
    logic [7:0]  latch_r,   latch_nxt;
    logic        psa_r,     psa_nxt;
    logic        nop_r,     nop_nxt;
    logic        ack_r,     ack_nxt;
    logic [31:0] rd_r,      rd_nxt;
    logic [7:0]  pinMeta_r, pinSync_r;
    logic        req,       accept,   busWr,   isInstr, isFile, exec;
    logic [13:0] opc;
    logic [6:0]  rdAddr,    wAddr;
    logic [7:0]  fileRd,    res,      wData;
    logic        wrEn,      memWe,    timerWr;
    logic        isXor,     isAddL,   isAndF,  isAddF,  isBclr;
    logic [8:0]  sum9;
    logic [4:0]  half5;

    // Bus decode; a write acts on the edge where the master sees ack
    assign req     = cycI & stbI;
    assign accept  = req & ack_r;
    assign busWr   = accept & weI;
    assign isInstr = (adrI == OFS_INSTR);
    assign isFile  = (adrI[11:9] == FILE_WIN);
    assign exec    = busWr & isInstr & (selI[1:0] == 2'b11);
    assign opc     = datI[13:0];
    assign isXor   = (opc[13:8] == OPC_XORLIT);
    assign isAddL  = (opc[13:9] == OPC_ADDLIT);
    assign isAndF  = (opc[13:8] == OPC_ANDF);
    assign isAddF  = (opc[13:8] == OPC_ADDF);
    assign isBclr  = (opc[13:10] == OPC_BCLR);
    assign rdAddr  = isFile ? adrI[8:2] : opc[6:0];

    // File read mux; the port address sees the synchronised pins
    always_comb begin
        unique case (rdAddr)
            F_TIMER:  fileRd = timer_r;
            F_IPLOW:  fileRd = ip_r[7:0];
            F_STATUS: fileRd = {5'h00, status_r};
            F_PORT:   fileRd = pinSync_r;
            default:  fileRd = mem[rdAddr];
        endcase
    end

    // Adder shared by both add ops so flag derivation stays identical
    always_comb begin
        sum9  = {1'b0, acc_r} + {1'b0, (isAddL ? opc[7:0] : fileRd)};
        half5 = {1'b0, acc_r[3:0]} + {1'b0, (isAddL ? opc[3:0] : fileRd[3:0])};
    end

    // Next-state logic for the whole datapath and bus slave
    always_comb begin
        acc_nxt    = acc_r;
        status_nxt = status_r;
        timer_nxt  = psa_r ? (presc_r == 8'hff ? timer_r + 8'h01 : timer_r)
                           : timer_r + 8'h01;
        presc_nxt  = presc_r + 8'h01;
        ip_nxt     = ip_r;
        latch_nxt  = latch_r;
        psa_nxt    = psa_r;
        // The dummy cycle stays pending until the next instruction access pays for it,
        // otherwise the idle cycle that the bus needs between requests would hide it
        nop_nxt    = nop_r & ~(req & isInstr);
        res        = 8'h00;
        wrEn       = 1'b0;
        wAddr      = rdAddr;
        wData      = 8'h00;
        memWe      = 1'b0;
        timerWr    = 1'b0;
        // Ack to an instruction access held off while the dummy cycle after a jump is pending
        ack_nxt    = req & ~ack_r & ~(nop_r & isInstr);
        rd_nxt     = 32'h0000_0000;
        if (ack_nxt) begin
            if (isFile) begin
                rd_nxt = {24'h000000, fileRd};
            end else begin
                unique case (adrI)
                    OFS_INSTR:  rd_nxt = {19'h00000, ip_r};
                    OFS_ACC:    rd_nxt = {24'h000000, acc_r};
                    OFS_STATUS: rd_nxt = {28'h0000000, nop_r, status_r};
                    OFS_CTRL:   rd_nxt = {31'h00000000, psa_r};
                    OFS_TIMER:  rd_nxt = {24'h000000, timer_r};
                    OFS_PRESC:  rd_nxt = {24'h000000, presc_r};
                    OFS_IPTR:   rd_nxt = {19'h00000, ip_r};
                    default:    rd_nxt = 32'h0000_0000;
                endcase
            end
        end
        // Plain register writes from the bus
        if (busWr & selI[0] & ~isFile) begin
            unique case (adrI)
                OFS_ACC:    acc_nxt    = datI[7:0];
                OFS_STATUS: status_nxt = datI[2:0];
                OFS_CTRL:   psa_nxt    = datI[CTRL_PSA];
                default:    ;
            endcase
        end
        if (busWr & selI[0] & isFile) begin
            wrEn  = 1'b1;
            wData = datI[7:0];
        end
        // Instruction execution, one cycle each
        if (exec) begin
            ip_nxt = ip_r + 13'h0001;
            if (isXor) begin
                acc_nxt          = acc_r ^ opc[7:0];
                status_nxt[ST_Z] = (acc_nxt == 8'h00);
            end else if (isAddL) begin
                acc_nxt           = sum9[7:0];
                status_nxt[ST_C]  = sum9[8];
                status_nxt[ST_DC] = half5[4];
                status_nxt[ST_Z]  = (sum9[7:0] == 8'h00);
            end else if (isAndF | isAddF) begin
                res = isAndF ? (acc_r & fileRd) : sum9[7:0];
                if (opc[7]) begin
                    wrEn  = 1'b1;
                    wData = res;
                end else begin
                    acc_nxt = res;
                end
            end else if (isBclr) begin
                wrEn  = 1'b1;
                wData = fileRd & ~(8'h01 << opc[9:7]);
            end
        end
        // File write routing with side effects of special addresses
        if (wrEn) begin
            unique case (wAddr)
                F_TIMER: begin
                    timer_nxt = wData;
                    timerWr   = 1'b1;
                    if (psa_r) begin
                        presc_nxt = RST_PRESC;
                    end
                end
                F_IPLOW: begin
                    ip_nxt  = {ip_r[12:8], wData};
                    if (exec) begin
                        nop_nxt = 1'b1;
                    end
                end
                F_STATUS: status_nxt = wData[2:0];
                F_PORT:   latch_nxt  = wData;
                default:  memWe      = 1'b1;
            endcase
        end
        // Flags land after routing so they beat a write to the status file
        if (exec & (isAndF | isAddF)) begin
            status_nxt[ST_Z] = (res == 8'h00);
            if (isAddF) begin
                status_nxt[ST_C]  = sum9[8];
                status_nxt[ST_DC] = half5[4];
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_r     <= RST_ACC;
            status_r  <= RST_STATUS;
            timer_r   <= RST_TIMER;
            presc_r   <= RST_PRESC;
            ip_r      <= RST_IPTR;
            latch_r   <= RST_LATCH;
            psa_r     <= RST_PSA;
            nop_r     <= 1'b0;
            ack_r     <= 1'b0;
            rd_r      <= 32'h0000_0000;
            pinMeta_r <= 8'h00;
            pinSync_r <= 8'h00;
        end else begin
            acc_r     <= acc_nxt;
            status_r  <= status_nxt;
            timer_r   <= timer_nxt;
            presc_r   <= presc_nxt;
            ip_r      <= ip_nxt;
            latch_r   <= latch_nxt;
            psa_r     <= psa_nxt;
            nop_r     <= nop_nxt;
            ack_r     <= ack_nxt;
            rd_r      <= rd_nxt;
            pinMeta_r <= portPins;
            pinSync_r <= pinMeta_r;
        end
    end

    // General file RAM; contents are undefined after reset, as in a real core
    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[wAddr] <= wData;
        end
    end

    assign ackO    = ack_r;
    assign datO    = rd_r;
    assign portOut = latch_r;

    // Checks
    property p_xor_lit;
        @(posedge clk) disable iff (!resetn)
        exec && isXor |=> acc_r == ($past(acc_r) ^ $past(opc[7:0]))
            && status_r[1:0] == $past(status_r[1:0])
            && status_r[ST_Z] == (acc_r == 8'h00);
    endproperty
    a_xor_lit: assert property (p_xor_lit) else $error("xor immediate wrong");

    property p_port_rmw;
        @(posedge clk) disable iff (!resetn)
        exec && isAndF && opc[7] && opc[6:0] == F_PORT
            |=> portOut == ($past(acc_r) & $past(pinSync_r));
    endproperty
    a_port_rmw: assert property (p_port_rmw) else $error("port rmw used latch");

    // Prescaler restarts from zero and keeps counting afterwards
    sequence s_presc_restart;
        presc_r == 8'h00 ##1 presc_r == 8'h01;
    endsequence
    property p_presc_clr;
        @(posedge clk) disable iff (!resetn)
        timerWr && psa_r |=> s_presc_restart;
    endproperty
    a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared");

    property p_nop_set;
        @(posedge clk) disable iff (!resetn)
        exec && wrEn && wAddr == F_IPLOW |=> nop_r && !ackO;
    endproperty
    a_nop_set: assert property (p_nop_set) else $error("jump left no dummy cycle");

    // The instruction access that meets a pending dummy cycle waits one extra cycle
    sequence s_dummy;
        !ackO ##1 !nop_r && !ackO && $stable(ip_r) ##1 ackO == $past(req);
    endsequence
    property p_two_cycle;
        @(posedge clk) disable iff (!resetn)
        nop_r && req && isInstr |-> s_dummy;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("jump not two cycles");

    property p_add_lit;
        @(posedge clk) disable iff (!resetn)
        exec && isAddL |=> acc_r == $past(acc_r) + $past(opc[7:0]);
    endproperty
    a_add_lit: assert property (p_add_lit) else $error("add immediate wrong");

    property p_and_file;
        @(posedge clk) disable iff (!resetn)
        exec && isAndF && !opc[7] |=> acc_r == ($past(acc_r) & $past(fileRd))
            && status_r[ST_Z] == (acc_r == 8'h00);
    endproperty
    a_and_file: assert property (p_and_file) else $error("and file wrong");

    property p_add_file_dest;
        @(posedge clk) disable iff (!resetn)
        exec && isAddF |=> (acc_r == $past(acc_r)) == $past(opc[7])
            || $past(fileRd) == 8'h00;
    endproperty
    a_add_file_dest: assert property (p_add_file_dest) else $error("add file dest");

    property p_bit_clear;
        @(posedge clk) disable iff (!resetn)
        exec && isBclr && memWe |-> !wData[opc[9:7]]
            ##1 status_r == $past(status_r);
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

    property p_carry;
        @(posedge clk) disable iff (!resetn)
        exec && isAddL |=> status_r[ST_C] == $past(sum9[8])
            && status_r[ST_DC] == $past(half5[4]);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flags wrong");

    // Flags of the file add worked out from the operands, not from the shared adder
    property p_add_file_flags;
        @(posedge clk) disable iff (!resetn)
        exec && isAddF |=>
            status_r[ST_C] == ({1'b0, $past(acc_r)} + {1'b0, $past(fileRd)} > 9'h0ff)
            && status_r[ST_DC] == ({1'b0, $past(acc_r[3:0])}
                                   + {1'b0, $past(fileRd[3:0])} > 5'h0f)
            && status_r[ST_Z] == (($past(acc_r) + $past(fileRd)) == 8'h00);
    endproperty
    a_add_file_flags: assert property (p_add_file_flags) else $error("add file flags");

    // Only the selected bit may differ between the old and the new file value
    property p_bit_keep;
        @(posedge clk) disable iff (!resetn)
        exec && isBclr && memWe |-> (wData ^ fileRd) == (fileRd & (8'h01 << opc[9:7]));
    endproperty
    a_bit_keep: assert property (p_bit_keep) else $error("bit clear hit other bits");

    // Ordinary instructions advance the pointer by one and cost no dummy cycle
    property p_ip_step;
        @(posedge clk) disable iff (!resetn)
        exec && !(wrEn && wAddr == F_IPLOW) |=> ip_r == $past(ip_r) + 13'h0001;
    endproperty
    a_ip_step: assert property (p_ip_step) else $error("pointer step wrong");

    // A timer write leaves an unassigned prescaler running
    property p_timer_keep;
        @(posedge clk) disable iff (!resetn)
        timerWr && !psa_r |=> presc_r == $past(presc_r) + 8'h01;
    endproperty
    a_timer_keep: assert property (p_timer_keep) else $error("prescaler cleared");
endmodule
`default_nettype wire

// ==== hw/alu_ops_pkg.sv ====
// Purpose: Constants for the literal and file-register ALU execution block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses, 20 MHz clock
// Notes:   Overview list below; offsets are aligned 32-bit words
//
// Overview of operation
// - Opcode 11_1010_kkkkkkkk XORs accumulator with literal, one cycle, only zero flag.
// - Read-modify-write of the I/O port reads the pin levels, not the latch.
// - Writing the timer counter clears the prescaler when assigned to the timer.
// - An instruction that changes the instruction pointer costs two cycles, the second a no-operation.
// - Add immediate sums accumulator and literal into accumulator; carry, half-carry, zero.
// - AND file ANDs accumulator with file; d=0 to accumulator, else file; zero flag.
// - Add file sums accumulator and file; d selects destination; carry, half-carry, zero.
// - Bit clear zeroes bit b of a file register; flags and other bits untouched.
`default_nettype none
package alu_ops_pkg;
    localparam int          ADR_W        = 12;
    // Wishbone register map (byte addresses)
    localparam logic [11:0] OFS_INSTR    = 12'h000;
    localparam logic [11:0] OFS_ACC      = 12'h004;
    localparam logic [11:0] OFS_STATUS   = 12'h008;
    localparam logic [11:0] OFS_CTRL     = 12'h00c;
    localparam logic [11:0] OFS_TIMER    = 12'h010;
    localparam logic [11:0] OFS_PRESC    = 12'h014;
    localparam logic [11:0] OFS_IPTR     = 12'h018;
    localparam logic [2:0]  FILE_WIN     = 3'h1;     // adr[11:9]: file window at 0x200
    // File addresses with side effects
    localparam logic [6:0]  F_TIMER      = 7'h01;
    localparam logic [6:0]  F_IPLOW      = 7'h02;
    localparam logic [6:0]  F_STATUS     = 7'h03;
    localparam logic [6:0]  F_PORT       = 7'h06;
    // Status bit positions
    localparam int          ST_C         = 0;
    localparam int          ST_DC        = 1;
    localparam int          ST_Z         = 2;
    localparam int          ST_BUSY      = 3;        // Read-only in STATUS word
    localparam int          CTRL_PSA     = 0;        // Prescaler assigned to timer
    // Opcode patterns, compared on the listed top bits
    localparam logic [5:0]  OPC_XORLIT   = 6'h3a;    // op[13:8]
    localparam logic [4:0]  OPC_ADDLIT   = 5'h1f;    // op[13:9]
    localparam logic [5:0]  OPC_ANDF     = 6'h05;    // op[13:8]
    localparam logic [5:0]  OPC_ADDF     = 6'h07;    // op[13:8]
    localparam logic [3:0]  OPC_BCLR     = 4'h4;     // op[13:10]
    // Reset values
    localparam logic [7:0]  RST_ACC      = 8'h00;
    localparam logic [2:0]  RST_STATUS   = 3'h0;
    localparam logic [7:0]  RST_TIMER    = 8'h00;
    localparam logic [7:0]  RST_PRESC    = 8'h00;
    localparam logic [12:0] RST_IPTR     = 13'h0000;
    localparam logic [7:0]  RST_LATCH    = 8'h00;
    localparam logic        RST_PSA      = 1'b0;
    localparam int          CLK_HZ       = 20_000_000;
endpackage
`default_nettype wire

// ==== dv/literal_and_file_alu_ops_tb.sv ====
// Purpose: Self-checking bench for the literal and file-register ALU block
// Assumes: Classic Wishbone slave; the bench is the only master
// Notes:   Flags are worked out here from operands, never read back as reference
`default_nettype none
module literal_and_file_alu_ops_tb
    import alu_ops_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk;
    logic              resetn;
    logic [ADR_W-1:0]  adrI;
    logic [31:0]       datI;
    logic [3:0]        selI;
    logic              weI;
    logic              cycI;
    logic              stbI;
    logic              ackO;
    logic [31:0]       datO;
    logic [7:0]        portPins;
    logic [7:0]        portOut;
    logic [31:0]       rdat;
    logic [31:0]       ip;
    logic [10:0]       e;
    logic [7:0]        av [4];
    logic [7:0]        kv [4];
    int                lat;
    int                n0;
    int                failures;
    int                total_checks;
    int                cycles;

    literal_file_alu dut (.clk(clk), .resetn(resetn), .adrI(adrI), .datI(datI), .selI(selI),
        .weI(weI), .cycI(cycI), .stbI(stbI), .ackO(ackO), .datO(datO),
        .portPins(portPins), .portOut(portOut));

    // Free-running 20 MHz clock
    always #25 clk = ~clk;

    // Hang guard: the whole sequence needs a few thousand cycles at most
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            close_out();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One classic cycle; request held until ack is sampled, then a dead cycle
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        adrI <= a;
        weI  <= w;
        datI <= d;
        selI <= s;
        cycI <= 1'b1;
        stbI <= 1'b1;
        lat = 0;
        do begin
            @(posedge clk);
            lat++;
        end while (ackO !== 1'b1 && lat < 40);
        // A slave that never answers ends the run through the common verdict
        if (ackO !== 1'b1) begin
            check("ack", 32'h0, 32'h1);
            close_out();
        end
        rdat = datO;
        cycI <= 1'b0;
        stbI <= 1'b0;
        weI  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 4'hf);
    endtask

    task automatic rd(input logic [11:0] a);
        bus(a, 1'b0, 32'h0, 4'hf);
    endtask

    // Opcode needs both low byte lanes
    task automatic exec(input logic [13:0] op);
        bus(OFS_INSTR, 1'b1, {18'h0, op}, 4'h3);
    endtask

    function automatic logic [11:0] fa(input logic [6:0] f);
        return {3'h1, f, 2'b00};
    endfunction

    // Returns {zero, half carry, carry, sum}
    function automatic logic [10:0] addx(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    // Main sequence: reset, then one block per behaviour
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {adrI, datI, selI, weI, cycI, stbI} = '0;
        portPins = 8'h00;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        av = '{8'h88, 8'h01, 8'h0f, 8'h40};
        kv = '{8'h88, 8'hff, 8'h01, 8'h20};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check("latch", {24'h0, portOut}, {24'h0, RST_LATCH});
        rd(OFS_ACC);
        check("acc", rdat, {24'h0, RST_ACC});
        rd(12'h01c);
        check("unmapped", rdat, 32'h0);
        // Xor touches only zero; pointer steps by one
        wr(OFS_STATUS, 32'h3);
        wr(OFS_ACC, 32'h5a);
        rd(OFS_IPTR);
        ip = rdat;
        exec({OPC_XORLIT, 8'h5a});
        n0 = lat;
        rd(OFS_ACC);
        check("acc", rdat, 32'h0);
        rd(OFS_STATUS);
        check("status", rdat & 32'h7, 32'h7);
        rd(OFS_IPTR);
        check("iptr", (rdat - ip) & 32'h1fff, 32'h1);
        exec({OPC_XORLIT, 8'h0f});
        rd(OFS_STATUS);
        check("status", rdat & 32'h7, 32'h3);
        // Add immediate, carries at both nibble and byte boundaries
        for (int i = 0; i < 4; i++) begin
            wr(OFS_ACC, {24'h0, av[i]});
            exec({OPC_ADDLIT, 1'b0, kv[i]});
            e = addx(av[i], kv[i]);
            rd(OFS_ACC);
            check("acc", rdat, {24'h0, e[7:0]});
            rd(OFS_STATUS);
            check("status", rdat & 32'h7, {29'h0, e[10:8]});
        end
        // And/add with file for both destinations, top file address for add
        for (int d = 0; d < 2; d++) begin
            wr(fa(7'h20), 32'hf0);
            wr(OFS_ACC, d ? 32'h0f : 32'h3c);
            exec({OPC_ANDF, d[0], 7'h20});
            rd(OFS_ACC);
            check("acc", rdat, d ? 32'h0f : 32'h30);
            rd(fa(7'h20));
            check("file", rdat & 32'hff, d ? 32'h00 : 32'hf0);
            rd(OFS_STATUS);
            check("zero", rdat & 32'h4, d ? 32'h4 : 32'h0);
            wr(fa(7'h7f), 32'hc8);
            wr(OFS_ACC, 32'h38);
            exec({OPC_ADDF, d[0], 7'h7f});
            e = addx(8'h38, 8'hc8);
            rd(OFS_ACC);
            check("acc", rdat, d ? 32'h38 : {24'h0, e[7:0]});
            rd(fa(7'h7f));
            check("file", rdat & 32'hff, d ? {24'h0, e[7:0]} : 32'hc8);
            rd(OFS_STATUS);
            check("status", rdat & 32'h7, {29'h0, e[10:8]});
        end
        // Bit clear every position; flags stay as written
        wr(OFS_STATUS, 32'h5);
        for (int b = 0; b < 8; b++) begin
            wr(fa(7'h22), 32'hff);
            exec({OPC_BCLR, b[2:0], 7'h22});
            rd(fa(7'h22));
            check("file", rdat & 32'hff, 32'hff & ~(32'h1 << b));
            rd(OFS_STATUS);
            check("status", rdat & 32'h7, 32'h5);
        end
        // Port read-modify-write takes pin levels, not the latch
        wr(fa(F_PORT), 32'hff);
        check("latch", {24'h0, portOut}, 32'hff);
        portPins <= 8'h3c;
        repeat (4) @(posedge clk);
        wr(OFS_ACC, 32'hff);
        exec({OPC_ANDF, 1'b1, F_PORT});
        check("latch", {24'h0, portOut}, 32'h3c);
        // Timer write clears prescaler only when assigned; mid-range start avoids wrap
        for (int p = 1; p >= 0; p--) begin
            wr(OFS_CTRL, p ? 32'h1 : 32'h0);
            wr(OFS_ACC, 32'h0);
            rd(OFS_PRESC);
            while (rdat[7:6] !== 2'b01) rd(OFS_PRESC);
            exec({OPC_ANDF, 1'b1, F_TIMER});
            rd(OFS_PRESC);
            check("presc", {31'h0, (rdat & 32'hff) < 32'h10}, p ? 32'h1 : 32'h0);
            if (p) begin
                rd(OFS_TIMER);
                check("timer", rdat & 32'hff, 32'h0);
            end
        end
        // Pointer write costs a dummy cycle before the next instruction
        exec({OPC_ADDF, 1'b1, F_IPLOW});
        exec({OPC_XORLIT, 8'h00});
        check("latency", lat, n0 + 1);
        exec({OPC_XORLIT, 8'h00});
        check("latency", lat, n0);
        close_out();
    end
endmodule
`default_nettype wire
